// *** rtl/mmu_translation_protection.sv ***
// mmu_translation_protection: operating mode, translation lookaside buffer and
// page protection for a 32-bit soft processor, registers over AXI4-Lite
// assumes the pipeline offers one access per cycle and takes exceptions itself
//
// Function
// - any exception taken, including reset and break, returns to supervisor mode.
// - user mode exists only when the translation unit is built in.
// - without the translation unit everything runs with supervisor privileges.
// - user mode rejects privileged instructions; supervisor mode permits them.
// - user access to a location not open to user mode faults and is blocked.
// - pages and frames are fixed 4 KByte units.
// - virtual address splits into 20-bit page number and 12-bit offset.
// - lookup key is page number plus process identifier, giving frame number.
// - physical address is frame number joined to the untranslated offset.
// - hardware never walks the page table; only software loads entries.
// - each page carries its own read, write and execute permission.
// - each mapped data page also says whether it is cacheable.
// - a miss or missing permission raises a precise fault for refill.
// - virtual space splits into user and supervisor partitions by fixed ranges.
// - bus address is always the translated or bypassed physical address.
// - top two partitions bypass, rest translate; only user range open to user.
// - bypassed accesses clear the three top address bits.
// - a global entry ignores the process identifier in lookup.
// - process identifier width is a build parameter from 8 to 14.
`timescale 1ns/10ps

module mmu_translation_protection #(
  parameter int HAS_MMU = 1,
  parameter int PID_W = mmu_pkg::PID_W_DEFAULT,
  parameter int NUM_ENTRIES = mmu_pkg::NUM_ENTRIES_DEFAULT
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [mmu_pkg::AXI_ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [mmu_pkg::AXI_ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic req_valid_i,
  input wire logic [31:0] req_vaddr_i,
  input wire logic [1:0] req_kind_i,
  input wire logic req_io_i,
  input wire logic req_priv_instr_i,
  input wire logic exc_taken_i,
  input wire logic ret_user_i,
  output logic bus_valid_o,
  output logic [31:0] bus_paddr_o,
  output logic [1:0] bus_kind_o,
  output logic bus_cacheable_o,
  output logic fault_o,
  output logic [2:0] fault_cause_o,
  output logic [31:0] fault_vaddr_o,
  output logic user_mode_o
);

  localparam int IDX_W = (NUM_ENTRIES > 1) ? $clog2(NUM_ENTRIES) : 1;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic global_map;
    logic [PID_W-1:0] process_identifier;
    logic [mmu_pkg::VPN_W-1:0] virtual_page_number;
    logic [mmu_pkg::VPN_W-1:0] physical_frame_number;
    logic cacheable;
    logic can_read;
    logic can_write;
    logic can_exec;
  } entry_t;

  typedef struct packed {
    entry_t [NUM_ENTRIES-1:0] tlb;
    logic [PID_W-1:0] proc_id;
    logic [IDX_W-1:0] index;
    logic [mmu_pkg::VPN_W-1:0] stage_vpn;
    logic stage_global;
    logic stage_valid;
    logic [PID_W-1:0] stage_pid;
    logic user_mode;
    logic bus_valid;
    logic [31:0] bus_paddr;
    logic [1:0] bus_kind;
    logic bus_cacheable;
    logic fault;
    logic [2:0] fault_cause;
    logic [31:0] fault_vaddr;
    logic aw_held;
    logic [mmu_pkg::AXI_ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_t;

  state_t st_reg;
  state_t st_next;

  logic [NUM_ENTRIES-1:0] hit_vec;
  logic hit_any;
  logic [IDX_W-1:0] hit_idx;
  entry_t hit_e;
  logic region_io;
  logic region_kernel;
  logic bypass;
  logic perm_ok;
  logic [2:0] cause;
  logic [31:0] paddr;
  logic cacheable;
  logic [31:0] wr_old;
  logic wr_ok;
  logic [31:0] wr_val;
  logic [31:0] rd_val;
  logic rd_ok;

  // ---------------------------------------------------------------
  // register readback
  // ---------------------------------------------------------------
  function automatic logic [31:0] reg_read(input state_t s, input logic [7:0] a, output logic ok);
    logic [31:0] v;
    entry_t e;
    v = mmu_pkg::REG_RESET;
    e = s.tlb[s.index];
    ok = 1'b1;
    case ({a[7:2], 2'h0})
      mmu_pkg::OFF_PROC_ID: v[PID_W-1:0] = s.proc_id;
      mmu_pkg::OFF_TLB_INDEX: v[IDX_W-1:0] = s.index;
      mmu_pkg::OFF_TLB_TAG:
      begin
        v[mmu_pkg::VPN_W-1:0] = s.stage_vpn;
        v[mmu_pkg::TAG_GLOBAL_BIT] = s.stage_global;
        v[mmu_pkg::TAG_VALID_BIT] = s.stage_valid;
      end
      mmu_pkg::OFF_TLB_PID: v[PID_W-1:0] = s.stage_pid;
      mmu_pkg::OFF_TLB_DATA:
      begin
        v[mmu_pkg::VPN_W-1:0] = e.physical_frame_number;
        v[mmu_pkg::DATA_CACHE_BIT] = e.cacheable;
        v[mmu_pkg::DATA_READ_BIT] = e.can_read;
        v[mmu_pkg::DATA_WRITE_BIT] = e.can_write;
        v[mmu_pkg::DATA_EXEC_BIT] = e.can_exec;
      end
      mmu_pkg::OFF_FAULT_STAT:
      begin
        v[2:0] = s.fault_cause;
        v[mmu_pkg::STAT_MODE_BIT] = s.user_mode;
      end
      mmu_pkg::OFF_FAULT_ADDR: v = s.fault_vaddr;
      default: ok = 1'b0;
    endcase
    return v;
  endfunction

  // ---------------------------------------------------------------
  // lookup
  // ---------------------------------------------------------------
  // one comparator per entry
  for (genvar g = 0; g < NUM_ENTRIES; g++)
  begin : g_match
    tlb_entry_match #(.PID_W(PID_W)) u_match (
      .valid_i(st_reg.tlb[g].valid),
      .global_i(st_reg.tlb[g].global_map),
      .entry_pid_i(st_reg.tlb[g].process_identifier),
      .entry_vpn_i(st_reg.tlb[g].virtual_page_number),
      .lookup_vpn_i(req_vaddr_i[31:mmu_pkg::PAGE_OFFSET_W]),
      .lookup_pid_i(st_reg.proc_id),
      .hit_o(hit_vec[g])
    );
  end

  // lowest matching entry wins; duplicate mappings are software's fault
  always_comb
  begin
    hit_any = 1'b0;
    hit_idx = '0;
    for (int i = NUM_ENTRIES - 1; i >= 0; i--)
    begin
      if (hit_vec[i])
      begin
        hit_any = 1'b1;
        hit_idx = IDX_W'(i);
      end
    end
    hit_e = st_reg.tlb[hit_idx];
  end

  // partition decode, permission check and physical address
  always_comb
  begin
    region_io = (req_vaddr_i[31:29] == mmu_pkg::IO_TOP3);
    region_kernel = (req_vaddr_i[31:29] == mmu_pkg::KERNEL_TOP3);
    bypass = (HAS_MMU != 0) && (region_io || region_kernel);
    case (req_kind_i)
      mmu_pkg::ACC_FETCH: perm_ok = hit_e.can_exec;
      mmu_pkg::ACC_LOAD: perm_ok = hit_e.can_read;
      mmu_pkg::ACC_STORE: perm_ok = hit_e.can_write;
      default: perm_ok = 1'b0;
    endcase
    cause = mmu_pkg::FC_NONE;
    if (HAS_MMU != 0)
    begin
      if (st_reg.user_mode && req_priv_instr_i)
        cause = mmu_pkg::FC_PRIV;
      else if (st_reg.user_mode && req_vaddr_i[31])
        cause = mmu_pkg::FC_SUPER;
      else if (!bypass && !hit_any)
        cause = mmu_pkg::FC_MISS;
      else if (!bypass && !perm_ok)
        cause = mmu_pkg::FC_PERM;
    end
    if (HAS_MMU == 0)
      paddr = req_vaddr_i;
    else if (bypass)
      paddr = {{mmu_pkg::BYPASS_CLEAR_W{1'b0}}, req_vaddr_i[28:0]};
    else
      paddr = {hit_e.physical_frame_number, req_vaddr_i[mmu_pkg::PAGE_OFFSET_W-1:0]};
    if (req_io_i || (HAS_MMU != 0 && region_io))
      cacheable = 1'b0;
    else if (HAS_MMU == 0 || region_kernel)
      cacheable = 1'b1;
    else
      cacheable = hit_e.cacheable;
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    st_next = st_reg;
    st_next.bus_valid = 1'b0;
    st_next.fault = 1'b0;
    wr_old = reg_read(st_reg, st_reg.aw_addr, wr_ok);
    for (int b = 0; b < 4; b++)
      wr_val[b*8 +: 8] = st_reg.w_strb[b] ? st_reg.w_data[b*8 +: 8] : wr_old[b*8 +: 8];
    rd_val = reg_read(st_reg, s_axi_araddr_i, rd_ok);
    // translation answers one cycle after the request
    if (req_valid_i)
    begin
      st_next.bus_kind = req_kind_i;
      if (cause != mmu_pkg::FC_NONE)
      begin
        st_next.fault = 1'b1;
        st_next.fault_cause = cause;
        st_next.fault_vaddr = req_vaddr_i;
      end
      else
      begin
        st_next.bus_valid = 1'b1;
        st_next.bus_paddr = paddr;
        st_next.bus_cacheable = cacheable;
      end
    end
    // mode: exceptions win over a return to user mode
    if (exc_taken_i || (req_valid_i && cause != mmu_pkg::FC_NONE))
      st_next.user_mode = 1'b0;
    else if (ret_user_i && HAS_MMU != 0)
      st_next.user_mode = 1'b1;
    // write channel capture
    if (s_axi_awvalid_i && st_reg.awready)
    begin
      st_next.aw_held = 1'b1;
      st_next.aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && st_reg.wready)
    begin
      st_next.w_held = 1'b1;
      st_next.w_data = s_axi_wdata_i;
      st_next.w_strb = s_axi_wstrb_i;
    end
    if (st_reg.bvalid && s_axi_bready_i)
      st_next.bvalid = 1'b0;
    // entries change only here, from software writes
    if (st_reg.aw_held && st_reg.w_held && !st_reg.bvalid)
    begin
      st_next.aw_held = 1'b0;
      st_next.w_held = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = mmu_pkg::RESP_OKAY;
      case ({st_reg.aw_addr[7:2], 2'h0})
        mmu_pkg::OFF_PROC_ID: st_next.proc_id = wr_val[PID_W-1:0];
        mmu_pkg::OFF_TLB_INDEX: st_next.index = wr_val[IDX_W-1:0];
        mmu_pkg::OFF_TLB_TAG:
        begin
          st_next.stage_vpn = wr_val[mmu_pkg::VPN_W-1:0];
          st_next.stage_global = wr_val[mmu_pkg::TAG_GLOBAL_BIT];
          st_next.stage_valid = wr_val[mmu_pkg::TAG_VALID_BIT];
        end
        mmu_pkg::OFF_TLB_PID: st_next.stage_pid = wr_val[PID_W-1:0];
        mmu_pkg::OFF_TLB_DATA:
        begin
          st_next.tlb[st_reg.index] = {st_reg.stage_valid, st_reg.stage_global, st_reg.stage_pid,
            st_reg.stage_vpn, wr_val[mmu_pkg::VPN_W-1:0], wr_val[mmu_pkg::DATA_CACHE_BIT],
            wr_val[mmu_pkg::DATA_READ_BIT], wr_val[mmu_pkg::DATA_WRITE_BIT],
            wr_val[mmu_pkg::DATA_EXEC_BIT]};
        end
        default: st_next.bresp = mmu_pkg::RESP_SLVERR;
      endcase
    end
    st_next.awready = !st_next.aw_held && !st_next.bvalid;
    st_next.wready = !st_next.w_held && !st_next.bvalid;
    // read channel, answer one cycle after the address
    if (st_reg.rvalid && s_axi_rready_i)
      st_next.rvalid = 1'b0;
    if (s_axi_arvalid_i && st_reg.arready)
    begin
      st_next.rvalid = 1'b1;
      st_next.rdata = rd_ok ? rd_val : mmu_pkg::REG_RESET;
      st_next.rresp = rd_ok ? mmu_pkg::RESP_OKAY : mmu_pkg::RESP_SLVERR;
    end
    st_next.arready = !st_next.rvalid;
  end

  // registered state, reset to all zero
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign s_axi_awready_o = st_reg.awready;
  assign s_axi_wready_o = st_reg.wready;
  assign s_axi_bvalid_o = st_reg.bvalid;
  assign s_axi_bresp_o = st_reg.bresp;
  assign s_axi_arready_o = st_reg.arready;
  assign s_axi_rvalid_o = st_reg.rvalid;
  assign s_axi_rdata_o = st_reg.rdata;
  assign s_axi_rresp_o = st_reg.rresp;
  assign bus_valid_o = st_reg.bus_valid;
  assign bus_paddr_o = st_reg.bus_paddr;
  assign bus_kind_o = st_reg.bus_kind;
  assign bus_cacheable_o = st_reg.bus_cacheable;
  assign fault_o = st_reg.fault;
  assign fault_cause_o = st_reg.fault_cause;
  assign fault_vaddr_o = st_reg.fault_vaddr;
  assign user_mode_o = st_reg.user_mode;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  property p_exc_super;
    exc_taken_i |=> !user_mode_o;
  endproperty
  a_exc_super: assert property (p_exc_super) else $error("mode not supervisor after exception");

  property p_no_user_without_mmu;
    (HAS_MMU == 0) |-> !user_mode_o;
  endproperty
  a_no_user_without_mmu: assert property (p_no_user_without_mmu) else $error("user mode without mmu");

  property p_priv_instr;
    req_valid_i && user_mode_o && req_priv_instr_i |=> fault_o && fault_cause_o == mmu_pkg::FC_PRIV;
  endproperty
  a_priv_instr: assert property (p_priv_instr) else $error("privileged instruction not refused");

  property p_user_super_addr;
    req_valid_i && user_mode_o && req_vaddr_i[31] |=> fault_o && !bus_valid_o;
  endproperty
  a_user_super_addr: assert property (p_user_super_addr) else $error("user reached supervisor range");

  property p_bypass_addr;
    req_valid_i && !user_mode_o && (HAS_MMU != 0) && req_vaddr_i[31:30] == 2'h3
      |=> bus_valid_o && bus_paddr_o == {3'h0, $past(req_vaddr_i[28:0])};
  endproperty
  a_bypass_addr: assert property (p_bypass_addr) else $error("bypass address wrong");

  property p_offset_kept;
    req_valid_i ##1 bus_valid_o |-> bus_paddr_o[11:0] == $past(req_vaddr_i[11:0]);
  endproperty
  a_offset_kept: assert property (p_offset_kept) else $error("page offset altered");

  property p_miss_fault;
    req_valid_i && !user_mode_o && (HAS_MMU != 0) && !req_vaddr_i[30] && !hit_any
      |=> fault_o && fault_cause_o == mmu_pkg::FC_MISS && fault_vaddr_o == $past(req_vaddr_i);
  endproperty
  a_miss_fault: assert property (p_miss_fault) else $error("miss not reported");

  property p_fault_no_bus;
    fault_o |-> !bus_valid_o;
  endproperty
  a_fault_no_bus: assert property (p_fault_no_bus) else $error("faulting access on bus");

  property p_global_hit;
    st_reg.tlb[0].valid && st_reg.tlb[0].global_map && st_reg.tlb[0].virtual_page_number == req_vaddr_i[31:12] |-> hit_vec[0];
  endproperty
  a_global_hit: assert property (p_global_hit) else $error("global entry missed");

  c_translated_hit: cover property (req_valid_i && !req_vaddr_i[30] && hit_any ##1 bus_valid_o);
  c_miss: cover property (req_valid_i ##1 fault_o && fault_cause_o == mmu_pkg::FC_MISS);
  c_bypass: cover property (req_valid_i && req_vaddr_i[31:30] == 2'h3 ##1 bus_valid_o);
  c_user_priv: cover property (ret_user_i ##1 user_mode_o ##[1:8] fault_o);

endmodule

// *** inc/mmu_pkg.sv ***
// mmu_pkg: shared constants for the translation and protection block
// assumes a 32-bit virtual address, 4 KByte pages and an AXI4-Lite register port

package mmu_pkg;

  // ---------------------------------------------------------------
  // address layout
  // ---------------------------------------------------------------
  localparam int VADDR_W = 32;
  localparam int PAGE_OFFSET_W = 12;
  localparam int VPN_W = 20;
  localparam int BYPASS_CLEAR_W = 3;
  localparam logic [2:0] IO_TOP3 = 3'h7;
  localparam logic [2:0] KERNEL_TOP3 = 3'h6;
  localparam int PID_W_DEFAULT = 8;
  localparam int PID_W_MIN = 8;
  localparam int PID_W_MAX = 14;
  localparam int NUM_ENTRIES_DEFAULT = 8;

  // ---------------------------------------------------------------
  // access kinds and fault causes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ACC_FETCH = 2'h0,
    ACC_LOAD = 2'h1,
    ACC_STORE = 2'h2
  } access_kind_t;

  typedef enum logic [2:0] {
    FC_NONE = 3'h0,
    FC_MISS = 3'h1,
    FC_PERM = 3'h2,
    FC_SUPER = 3'h3,
    FC_PRIV = 3'h4
  } fault_cause_t;

  // ---------------------------------------------------------------
  // register map, byte addresses
  // ---------------------------------------------------------------
  localparam int AXI_ADDR_W = 8;
  localparam logic [7:0] OFF_PROC_ID = 8'h00;
  localparam logic [7:0] OFF_TLB_INDEX = 8'h04;
  localparam logic [7:0] OFF_TLB_TAG = 8'h08;
  localparam logic [7:0] OFF_TLB_PID = 8'h0c;
  localparam logic [7:0] OFF_TLB_DATA = 8'h10;
  localparam logic [7:0] OFF_FAULT_STAT = 8'h14;
  localparam logic [7:0] OFF_FAULT_ADDR = 8'h18;

  // field positions
  localparam int TAG_GLOBAL_BIT = 20;
  localparam int TAG_VALID_BIT = 21;
  localparam int DATA_CACHE_BIT = 20;
  localparam int DATA_READ_BIT = 21;
  localparam int DATA_WRITE_BIT = 22;
  localparam int DATA_EXEC_BIT = 23;
  localparam int STAT_MODE_BIT = 8;

  // reset value of every stored field
  localparam logic [31:0] REG_RESET = 32'h0000_0000;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// *** rtl/tlb_entry_match.sv ***
// tlb_entry_match: compares one translation entry against a lookup key
// assumes the caller holds the entry fields stable; purely combinational
`timescale 1ns/10ps

module tlb_entry_match #(
  parameter int PID_W = mmu_pkg::PID_W_DEFAULT
) (
  input wire logic valid_i,
  input wire logic global_i,
  input wire logic [PID_W-1:0] entry_pid_i,
  input wire logic [mmu_pkg::VPN_W-1:0] entry_vpn_i,
  input wire logic [mmu_pkg::VPN_W-1:0] lookup_vpn_i,
  input wire logic [PID_W-1:0] lookup_pid_i,
  output logic hit_o
);

  // key is page number plus process identifier, global entries skip the identifier
  assign hit_o = valid_i && (entry_vpn_i == lookup_vpn_i) &&
                 (global_i || (entry_pid_i == lookup_pid_i));

endmodule

// *** dv/pipe_model.sv ***
// pipe_model: stand-in for the processor pipeline issuing accesses
// assumes one clock; drives requests right after a rising edge
`timescale 1ns/10ps

module pipe_model (
  input wire logic clock_i,
  output logic req_valid_o,
  output logic [31:0] req_vaddr_o,
  output logic [1:0] req_kind_o,
  output logic req_io_o,
  output logic req_priv_instr_o,
  output logic exc_taken_o,
  output logic ret_user_o
);
  // ---------------------------------------------------------------
  // request driving
  // ---------------------------------------------------------------
  initial
  begin
    req_valid_o = 1'b0;
    req_vaddr_o = 32'h0000_0000;
    req_kind_o = 2'h0;
    req_io_o = 1'b0;
    req_priv_instr_o = 1'b0;
    exc_taken_o = 1'b0;
    ret_user_o = 1'b0;
  end

  // one access pulse; address inverted afterwards so no stale value looks valid
  task automatic issue(input logic [31:0] v, input logic [1:0] k, input logic io, input logic pr);
    @(posedge clock_i);
    req_valid_o <= 1'b1;
    req_vaddr_o <= v;
    req_kind_o <= k;
    req_io_o <= io;
    req_priv_instr_o <= pr;
    @(posedge clock_i);
    req_valid_o <= 1'b0;
    req_vaddr_o <= ~v;
    req_priv_instr_o <= 1'b0;
  endtask

  // one-cycle mode pulse: exception taken or return to user
  task automatic mode(input logic exc, input logic ret);
    @(posedge clock_i);
    exc_taken_o <= exc;
    ret_user_o <= ret;
    @(posedge clock_i);
    exc_taken_o <= 1'b0;
    ret_user_o <= 1'b0;
  endtask
endmodule

// *** dv/mmu_translation_protection_tb_top.sv ***
// mmu_translation_protection_tb_top: self-checking bench for the translation block
// assumes default parameters; registers reached over AXI4-Lite
`timescale 1ns/10ps

module mmu_translation_protection_tb_top;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic awready, wready, bvalid, arready, rvalid, rv, pio, ppr, pexc, pret;
  logic bus_valid, bus_cache, fault, umode, nm_valid, nm_fault, nm_umode;
  logic [1:0] bresp, rresp, bkind, pk, rsp;
  logic [31:0] rdata, pa, fva, paddr, rdv, nm_paddr;
  logic [2:0] cause;
  int err_count = 0;
  int n_checks = 0;

  always #10 clock_i = ~clock_i;

  pipe_model pipe_model_i (.clock_i(clock_i), .req_valid_o(rv), .req_vaddr_o(pa), .req_kind_o(pk),
    .req_io_o(pio), .req_priv_instr_o(ppr), .exc_taken_o(pexc), .ret_user_o(pret));

  mmu_translation_protection mmu_translation_protection_i (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .req_valid_i(rv), .req_vaddr_i(pa), .req_kind_i(pk), .req_io_i(pio), .req_priv_instr_i(ppr),
    .exc_taken_i(pexc), .ret_user_i(pret), .bus_valid_o(bus_valid), .bus_paddr_o(paddr),
    .bus_kind_o(bkind), .bus_cacheable_o(bus_cache), .fault_o(fault), .fault_cause_o(cause),
    .fault_vaddr_o(fva), .user_mode_o(umode));

  // copy built without translation, fed by the same pipeline requests
  mmu_translation_protection #(.HAS_MMU(0)) mmu_translation_protection_nommu_i (.clock_i(clock_i),
    .rst_n_i(rst_n_i), .s_axi_awaddr_i(8'h0), .s_axi_awvalid_i(1'b0), .s_axi_awready_o(),
    .s_axi_wdata_i(32'h0), .s_axi_wstrb_i(4'h0), .s_axi_wvalid_i(1'b0), .s_axi_wready_o(),
    .s_axi_bresp_o(), .s_axi_bvalid_o(), .s_axi_bready_i(1'b0), .s_axi_araddr_i(8'h0),
    .s_axi_arvalid_i(1'b0), .s_axi_arready_o(), .s_axi_rdata_o(), .s_axi_rresp_o(), .s_axi_rvalid_o(),
    .s_axi_rready_i(1'b0), .req_valid_i(rv), .req_vaddr_i(pa), .req_kind_i(pk), .req_io_i(pio),
    .req_priv_instr_i(ppr), .exc_taken_i(pexc), .ret_user_i(pret), .bus_valid_o(nm_valid),
    .bus_paddr_o(nm_paddr), .bus_kind_o(), .bus_cacheable_o(), .fault_o(nm_fault), .fault_cause_o(),
    .fault_vaddr_o(), .user_mode_o(nm_umode));

  // ---------------------------------------------------------------
  // reporting and comparison
  // ---------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  // a wait that runs out ends the run
  task automatic tmo(input int n);
    if (n > 50)
    begin
      chk("wait bound", 32'h0000_0000, 32'h0000_0001);
      final_report();
    end
  endtask

  // ---------------------------------------------------------------
  // bus cycles
  // ---------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clock_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do
    begin
      @(posedge clock_i);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      tmo(++n);
    end while ((awvalid && !awready) || (wvalid && !wready));
    bready <= 1'b1;
    do
    begin
      @(posedge clock_i);
      tmo(++n);
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clock_i);
    araddr <= a;
    arvalid <= 1'b1;
    do
    begin
      @(posedge clock_i);
      tmo(++n);
    end while (!arready);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do
    begin
      @(posedge clock_i);
      tmo(++n);
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic wr_ok(input logic [7:0] a, input logic [31:0] d);
    wr(a, d, rsp);
    chk("bresp", 32'(mmu_pkg::RESP_OKAY), 32'(rsp));
  endtask

  // access, then judge the answer in the following cycle
  task automatic acc_ok(input logic [31:0] v, input logic [1:0] k, input logic io, input logic [31:0] ep,
    input logic ec);
    pipe_model_i.issue(v, k, io, 1'b0);
    #1;
    chk("bus_valid", 32'h1, 32'(bus_valid));
    chk("fault", 32'h0, 32'(fault));
    chk("paddr", ep, paddr);
    chk("bus_kind", 32'(k), 32'(bkind));
    chk("cacheable", 32'(ec), 32'(bus_cache));
  endtask

  task automatic acc_flt(input logic [31:0] v, input logic [1:0] k, input logic pr, input logic [2:0] ec);
    pipe_model_i.issue(v, k, 1'b0, pr);
    #1;
    chk("bus_valid", 32'h0, 32'(bus_valid));
    chk("fault", 32'h1, 32'(fault));
    chk("cause", 32'(ec), 32'(cause));
    chk("fault_vaddr", v, fva);
    chk("user_mode", 32'h0, 32'(umode));
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_bypass();
    chk("user_mode", 32'h0, 32'(umode));
    rd(mmu_pkg::OFF_PROC_ID, rdv, rsp);
    chk("proc_id", mmu_pkg::REG_RESET, rdv);
    acc_ok(32'he000_1234, 2'h1, 1'b0, 32'h0000_1234, 1'b0);
    acc_ok(32'hc000_5678, 2'h0, 1'b0, 32'h0000_5678, 1'b1);
    acc_ok(32'hffff_fffc, 2'h2, 1'b0, 32'h1fff_fffc, 1'b0);
    acc_flt(32'h8000_3000, 2'h1, 1'b0, mmu_pkg::FC_MISS);
  endtask

  task automatic t_tlb();
    wr_ok(mmu_pkg::OFF_TLB_INDEX, 32'h0000_0000);
    wr_ok(mmu_pkg::OFF_TLB_TAG, 32'h0020_0012);
    wr_ok(mmu_pkg::OFF_TLB_PID, 32'h0000_0005);
    wr_ok(mmu_pkg::OFF_TLB_DATA, 32'h00b0_abcd);
    wr_ok(mmu_pkg::OFF_TLB_INDEX, 32'h0000_0001);
    wr_ok(mmu_pkg::OFF_TLB_TAG, 32'h0038_0034);
    wr_ok(mmu_pkg::OFF_TLB_PID, 32'h0000_0009);
    wr_ok(mmu_pkg::OFF_TLB_DATA, 32'h0060_0111);
    wr_ok(mmu_pkg::OFF_PROC_ID, 32'h0000_0005);
    acc_ok(32'h0001_2345, 2'h1, 1'b0, 32'h0abc_d345, 1'b1);
    acc_ok(32'h0001_2ffc, 2'h0, 1'b0, 32'h0abc_dffc, 1'b1);
    acc_ok(32'h0001_2008, 2'h1, 1'b1, 32'h0abc_d008, 1'b0);
    acc_flt(32'h0001_2010, 2'h2, 1'b0, mmu_pkg::FC_PERM);
    acc_flt(32'h0001_2014, 2'h3, 1'b0, mmu_pkg::FC_PERM);
    acc_flt(32'h0001_3000, 2'h1, 1'b0, mmu_pkg::FC_MISS);
    wr_ok(mmu_pkg::OFF_PROC_ID, 32'h0000_0006);
    acc_flt(32'h0001_2345, 2'h1, 1'b0, mmu_pkg::FC_MISS);
    acc_ok(32'h8003_4abc, 2'h2, 1'b0, 32'h0011_1abc, 1'b0);
    rd(mmu_pkg::OFF_TLB_DATA, rdv, rsp);
    chk("tlb_data", 32'h0060_0111, rdv);
  endtask

  task automatic t_user();
    wr_ok(mmu_pkg::OFF_PROC_ID, 32'h0000_0005);
    pipe_model_i.mode(1'b0, 1'b1);
    #1;
    chk("user_mode", 32'h1, 32'(umode));
    acc_ok(32'h0001_2100, 2'h1, 1'b0, 32'h0abc_d100, 1'b1);
    acc_flt(32'hc000_0000, 2'h1, 1'b0, mmu_pkg::FC_SUPER);
    pipe_model_i.mode(1'b0, 1'b1);
    acc_flt(32'h0001_2000, 2'h0, 1'b1, mmu_pkg::FC_PRIV);
    pipe_model_i.mode(1'b0, 1'b1);
    pipe_model_i.mode(1'b1, 1'b0);
    #1;
    chk("user_mode", 32'h0, 32'(umode));
    acc_ok(32'h0001_2000, 2'h0, 1'b0, 32'h0abc_d000, 1'b1);
  endtask

  task automatic t_regs();
    rd(mmu_pkg::OFF_FAULT_ADDR, rdv, rsp);
    chk("fault_addr", 32'h0001_2000, rdv);
    rd(mmu_pkg::OFF_FAULT_STAT, rdv, rsp);
    chk("fault_stat", 32'(mmu_pkg::FC_PRIV), rdv);
    wr(mmu_pkg::OFF_FAULT_STAT, 32'h0000_00ff, rsp);
    chk("bresp ro", 32'(mmu_pkg::RESP_SLVERR), 32'(rsp));
    rd(8'h1c, rdv, rsp);
    chk("rresp unmapped", 32'(mmu_pkg::RESP_SLVERR), 32'(rsp));
    chk("rdata unmapped", 32'h0000_0000, rdv);
  endtask

  // build without translation: flat addresses, no faults, never user mode
  task automatic t_nommu();
    pipe_model_i.mode(1'b0, 1'b1);
    pipe_model_i.issue(32'h8001_2345, 2'h2, 1'b0, 1'b1);
    #1;
    chk("nm valid", 32'h1, 32'(nm_valid));
    chk("nm fault", 32'h0, 32'(nm_fault));
    chk("nm paddr", 32'h8001_2345, nm_paddr);
    chk("nm mode", 32'h0, 32'(nm_umode));
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (5) @(posedge clock_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    t_bypass();
    t_tlb();
    t_user();
    t_regs();
    t_nommu();
    final_report();
  end
endmodule
